// ---- dv/ctst_host.sv ----
// Purpose: host side of the charge supervisor: status line and alert pulse counter
// Assumes: single clock, alert is an active-high one-cycle pulse
// Notes:   the status line is open drain with a pull-up
`timescale 1ns/1ps
module ctst_host (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic alert_i,
  input  wire logic stat_i,
  input  wire logic stat_oe_i,
  output logic      stat_line_o,
  output int        alert_cnt_o
);
  ////////////////////////////////////////////////////////////////////////
  // released pin floats up to the pull-up level, never the last value
  assign stat_line_o = stat_oe_i ? stat_i : 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // every pulse is one event, so a stuck-high alert shows as a run of counts
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alert_cnt_o <= 0;
    end else if (alert_i) begin
      alert_cnt_o <= alert_cnt_o + 1;
    end
  end
endmodule

// ---- dv/ctst_top_bench.sv ----
// Purpose: self-checking bench of the charge supervisor
// Assumes: timer tick shortened to 4 clock cycles
// Notes:   zone and loop cases run from a table, timers by hand
`timescale 1ns/1ps
module ctst_top_bench;
  import ctst_pkg::*;
  localparam int TK = 4;
  typedef struct packed {
    logic [8:0] cfg;
    logic [6:0] inp;
    logic [2:0] ph;
    logic       chg;
    logic [1:0] vs;
    logic [1:0] is;
  } ctst_row_t;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata, d;
  logic        icl = 0, ivl = 0, thr = 0, flt = 0, cold = 0, cool = 0, warm = 0, hot = 0;
  logic        rech = 0, term = 0, lowv = 0;
  logic        dis_pin = 0, shrt = 0, cvm = 0, bal = 0, sup = 0;
  logic        stat, stat_oe, alert, chg_on, stat_line;
  logic [2:0]  phase;
  logic [1:0]  vsel, isel;
  int          alert_cnt, a0, error_cnt = 0, num_checks = 0;
  ctst_row_t   rows [10];
  ////////////////////////////////////////////////////////////////////////
  always #12.5 clk_i = ~clk_i;
  ctst_top #(.TICK_CYC(TK)) ctst_top_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .charge_disable_pin_i(dis_pin), .vbat_above_recharge_i(rech),
    .ibat_below_term_i(term), .vbat_below_short_i(shrt), .vbat_below_lowv_i(lowv),
    .cv_mode_i(cvm), .input_current_loop_status_i(icl), .input_voltage_loop_i(ivl),
    .thermal_reg_i(thr), .balance_active_i(bal), .charge_fault_i(flt),
    .supplement_i(sup), .thermistor_cold_i(cold), .thermistor_cool_i(cool),
    .thermistor_warm_i(warm), .thermistor_hot_i(hot), .stat_o(stat), .stat_oe_o(stat_oe),
    .alert_o(alert),
    .charge_phase_code_o(phase), .chg_on_o(chg_on), .vreg_sel_o(vsel), .ichg_scale_o(isel));
  ctst_host ctst_host_i (.clk_i(clk_i), .rstn_i(rstn_i), .alert_i(alert), .stat_i(stat),
    .stat_oe_i(stat_oe), .stat_line_o(stat_line), .alert_cnt_o(alert_cnt));
  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // termination request on the next edge, then let it land
  task automatic end_cond(input logic v);
    @(posedge clk_i);
    rech <= v;
    term <= v;
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // run is about 65k cycles, so a hang is cut well past it
  initial begin
    repeat (90000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end
  initial begin
    //               cfg     icl..hot  ph    chg   vs     is
    rows[0] = '{9'h002, 7'h00, 3'h6, 1'b0, 2'h0, 2'h0};
    rows[1] = '{9'h002, 7'h40, 3'h3, 1'b1, 2'h0, 2'h0};
    rows[2] = '{9'h002, 7'h20, 3'h3, 1'b1, 2'h0, 2'h0};
    rows[3] = '{9'h002, 7'h10, 3'h3, 1'b1, 2'h0, 2'h0};
    rows[4] = '{9'h052, 7'h08, 3'h3, 1'b1, 2'h1, 2'h1};
    rows[5] = '{9'h022, 7'h08, 3'h3, 1'b1, 2'h2, 2'h0};
    rows[6] = '{9'h082, 7'h04, 3'h3, 1'b1, 2'h0, 2'h1};
    rows[7] = '{9'h102, 7'h04, 3'h3, 1'b1, 2'h0, 2'h2};
    rows[8] = '{9'h182, 7'h04, 3'h0, 1'b0, 2'h0, 2'h3};
    rows[9] = '{9'h002, 7'h02, 3'h0, 1'b0, 2'h0, 2'h0};
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    cyc(4);
    chk("phase_cc", phase, 3'h3);
    chk("stat_low", stat_line, 1'b0);
    @(posedge clk_i);
    shrt <= 1'b1;
    cyc(2);
    chk("phase_trickle", phase, 3'h1);
    @(posedge clk_i);
    {shrt, cvm} <= 2'b01;
    cyc(2);
    chk("phase_cv", phase, 3'h4);
    @(posedge clk_i);
    cvm <= 1'b0;
    rreg(4'h0, d);
    chk("ctrl_rst", d, 16'h000F);
    rreg(4'h4, d);
    chk("cfg_rst", d, 16'h0002);
    rreg(4'hC, d);
    chk("unmapped", d, 16'h0000);
    foreach (rows[k]) begin
      wreg(4'h4, {7'h00, rows[k].cfg});
      @(posedge clk_i);
      {icl, ivl, thr, warm, cool, cold, hot} <= rows[k].inp;
      cyc(4);
      end_cond(1'b1);
      chk("row_phase", phase, rows[k].ph);
      chk("row_chg", chg_on, rows[k].chg);
      chk("row_vsel", vsel, rows[k].vs);
      chk("row_isel", isel, rows[k].is);
      @(posedge clk_i);
      {icl, ivl, thr, warm, cool, cold, hot} <= 7'h00;
      end_cond(1'b0);
    end
    wreg(4'h4, 16'h0002);
    cyc(4);
    a0 = alert_cnt;
    end_cond(1'b1);
    chk("term_stat", stat_line, 1'b1);
    chk("term_alert", alert_cnt - a0, 1);
    end_cond(1'b0);
    wreg(4'h0, 16'h001F);
    a0 = alert_cnt;
    end_cond(1'b1);
    chk("mask_alert", alert_cnt - a0, 0);
    end_cond(1'b0);
    wreg(4'h0, 16'h000D);
    end_cond(1'b1);
    chk("term_off", phase, 3'h3);
    end_cond(1'b0);
    wreg(4'h0, 16'h000F);
    // 15 min top-off is 900 ticks; a later 45 min write must not stretch it
    wreg(4'h4, 16'h0006);
    a0 = alert_cnt;
    end_cond(1'b1);
    chk("topoff", phase, 3'h5);
    wreg(4'h4, 16'h000E);
    cyc(3400);
    chk("topoff_run", phase, 3'h5);
    cyc(400);
    chk("topoff_end", phase, 3'h6);
    chk("topoff_alerts", alert_cnt - a0, 2);
    end_cond(1'b0);
    wreg(4'h4, 16'h0006);
    end_cond(1'b1);
    @(posedge clk_i);
    bal <= 1'b1;
    cyc(3800);
    chk("topoff_half", phase, 3'h5);
    rreg(4'h8, d);
    chk("half_stat", d[5], 1'b1);
    chk("topoff_stat", d[6], 1'b1);
    cyc(3600);
    chk("topoff_half_end", phase, 3'h6);
    @(posedge clk_i);
    bal <= 1'b0;
    end_cond(1'b0);
    // defaults reset inside a running top-off must end it
    wreg(4'h4, 16'h0006);
    end_cond(1'b1);
    wreg(4'h0, 16'h0080);
    cyc(2);
    chk("defaults_topoff", phase, 3'h6);
    end_cond(1'b0);
    rreg(4'h4, d);
    chk("defaults_cfg", d, 16'h0002);
    rreg(4'h0, d);
    chk("defaults_ctrl", d, 16'h000F);
    // precharge limit is 7200 ticks; crossing and fault time must not count
    @(posedge clk_i);
    lowv <= 1'b1;
    cyc(4);
    chk("phase_pre", phase, 3'h2);
    cyc(20000);
    lowv <= 1'b0;
    cyc(2);
    lowv <= 1'b1;
    cyc(20000);
    flt <= 1'b1;
    cyc(2000);
    {flt, sup} <= 2'b01;
    cyc(2000);
    sup <= 1'b0;
    cyc(8000);
    chk("pre_run", phase, 3'h2);
    a0 = alert_cnt;
    cyc(1600);
    chk("pre_expire", phase, 3'h0);
    chk("fault_alert", alert_cnt - a0, 1);
    rreg(4'h8, d);
    chk("fault_stat", d[3], 1'b1);
    @(posedge clk_i);
    dis_pin <= 1'b1;
    @(posedge clk_i);
    dis_pin <= 1'b0;
    cyc(3);
    chk("restart_pre", phase, 3'h2);
    rreg(4'h8, d);
    chk("fault_clr", d[3], 1'b0);
    finish_test();
  end
endmodule

// ---- logic/ctst_if.sv ----
// Purpose: carries the timer tick from divider to supervisor
// Assumes: single clock
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
interface ctst_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// ---- logic/ctst_pkg.sv ----
// Purpose: shared types of the charge supervisor
// Assumes: nothing
// Notes:   state of each module is one packed struct
package ctst_pkg;
  typedef enum logic [1:0] {S_IDLE, S_CHG, S_TOPOFF, S_DONE} ctst_state_t;

  typedef struct packed {
    ctst_state_t st;
    logic [2:0]  phase;
    logic [4:0]  ctrl;
    logic [8:0]  cfg;
    logic [1:0]  to_sel;
    logic [16:0] st_cnt;
    logic [11:0] to_cnt;
    logic        hp;
    logic        tfault;
    logic        en_d;
    logic        lowv_d;
    logic        alert;
    logic        stat_oe;
    logic        stat_lvl;
    logic        chg_on;
    logic [1:0]  vsel;
    logic [1:0]  isel;
    logic [15:0] rdata;
  } ctst_core_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } ctst_div_t;
endpackage

// ---- logic/ctst_regs.svh ----
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 16-bit register data, 4-bit byte address
// Notes:   definitions only
`ifndef CTST_REGS_SVH
`define CTST_REGS_SVH
`define CTST_CTRL_OFS     4'h0
`define CTST_CFG_OFS      4'h4
`define CTST_STAT_OFS     4'h8
`define CTST_CTRL_EN      0
`define CTST_CTRL_TE      1
`define CTST_CTRL_TM      2
`define CTST_CTRL_HR      3
`define CTST_CTRL_MASK    4
`define CTST_CTRL_RSTB    7
`define CTST_CTRL_RST     5'h0F
`define CTST_CFG_FAST     1:0
`define CTST_CFG_TO       3:2
`define CTST_CFG_WV       5:4
`define CTST_CFG_WI       6
`define CTST_CFG_CI       8:7
`define CTST_CFG_RST      9'h002
`define CTST_PH_IDLE      3'h0
`define CTST_PH_TRICKLE   3'h1
`define CTST_PH_PRE       3'h2
`define CTST_PH_CC        3'h3
`define CTST_PH_CV        3'h4
`define CTST_PH_TOPOFF    3'h5
`define CTST_PH_DONE      3'h6
`define CTST_CLK_NS       25
`define CTST_TICK_NS      1000000000
`define CTST_S_PER_HR     3600
`define CTST_S_PER_MIN    60
`define CTST_PRE_HR       2
`define CTST_FAST0_HR     5
`define CTST_FAST1_HR     8
`define CTST_FAST2_HR     12
`define CTST_FAST3_HR     20
`define CTST_TO1_MIN      15
`define CTST_TO2_MIN      30
`define CTST_TO3_MIN      45
`endif

// ---- logic/ctst_tick.sv ----
// Purpose: divides the core clock down to the timer tick
// Assumes: TICK_CYC of at least 2
// Notes:   tick is registered
`timescale 1ns/1ps
module ctst_tick import ctst_pkg::*; #(
  parameter int TICK_CYC = 40000000
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  ctst_if.src       tk
);
  localparam logic [31:0] LAST = 32'(TICK_CYC - 1);

  ctst_div_t r;
  ctst_div_t next_r;

  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (r.cnt == LAST) begin // R23
      next_r.cnt  = 32'h0;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tk.tick = r.tick;
endmodule

// ---- logic/ctst_top.sv ----
// Purpose: charge cycle supervisor: termination, top-off, zones, safety timers
// Assumes: status inputs are synchronous to clk_i; zone inputs are one-hot or zero
// Notes:   all timers count whole ticks of the divider
//
// How it works
// R1: terminate above recharge and below termination current
// R2: on termination release status, code 110, alert
// R3: no termination during any regulation loop
// R4: termination disabled bit blocks termination until re-enabled
// R5: nonzero top-off runs after termination, code 101
// R6: top-off pauses and halves with safety timer
// R7: top-off expiry gives code 110 and alert
// R8: top-off count cleared on restart or reset
// R9: top-off duration latched at termination
// R10: event mask withholds phase change alerts, not the timer fault alert
// R11: charge only inside thermistor window
// R12: warm zone picks charge voltage selection
// R13: warm zone current 100% or 40%
// R14: cool zone current 100/40/20% or suspend
// R15: warm or cool zone blocks termination
// R16: fast-charge limit expiry sets fault, alerts
// R17: regulation or balancing halves timer rate
// R18: half-rate bit change keeps accumulated count
// R19: faults and supplement hold the count
// R20: restart and region crossing clear timer
// R21: two-hour precharge timer, same rules
// R22: phase code encoding 000 to 110
// R23: one tick, half rate on every second
`timescale 1ns/1ps
`include "ctst_regs.svh"
module ctst_top import ctst_pkg::*; #(
  parameter int TICK_CYC = `CTST_TICK_NS / `CTST_CLK_NS
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        charge_disable_pin_i,
  input  wire logic        vbat_above_recharge_i,
  input  wire logic        ibat_below_term_i,
  input  wire logic        vbat_below_short_i,
  input  wire logic        vbat_below_lowv_i,
  input  wire logic        cv_mode_i,
  input  wire logic        input_current_loop_status_i,
  input  wire logic        input_voltage_loop_i,
  input  wire logic        thermal_reg_i,
  input  wire logic        balance_active_i,
  input  wire logic        charge_fault_i,
  input  wire logic        supplement_i,
  input  wire logic        thermistor_cold_i,
  input  wire logic        thermistor_cool_i,
  input  wire logic        thermistor_warm_i,
  input  wire logic        thermistor_hot_i,
  output logic             stat_o,
  output logic             stat_oe_o,
  output logic             alert_o,
  output logic      [2:0]  charge_phase_code_o,
  output logic             chg_on_o,
  output logic      [1:0]  vreg_sel_o,
  output logic      [1:0]  ichg_scale_o
);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [16:0] fast_lim(input logic [1:0] sel);
    logic [31:0] h;
    case (sel)
      2'h0:    h = `CTST_FAST0_HR;
      2'h1:    h = `CTST_FAST1_HR;
      2'h2:    h = `CTST_FAST2_HR;
      default: h = `CTST_FAST3_HR;
    endcase
    return 17'(h * `CTST_S_PER_HR);
  endfunction

  function automatic logic [11:0] to_lim(input logic [1:0] sel);
    logic [31:0] m;
    case (sel)
      // a cleared selection ends a running top-off at once
      2'h0:    m = 32'h0000_0000; // R8
      2'h1:    m = `CTST_TO1_MIN;
      2'h2:    m = `CTST_TO2_MIN;
      default: m = `CTST_TO3_MIN;
    endcase
    return 12'(m * `CTST_S_PER_MIN);
  endfunction

  function automatic logic [2:0] phase_of(input ctst_state_t s, input logic hold,
                                          input logic sht, input logic lowv,
                                          input logic cv);
    logic [2:0] p;
    case (s) // R22
      S_CHG: begin
        if (hold) begin
          p = `CTST_PH_IDLE;
        end else if (sht) begin
          p = `CTST_PH_TRICKLE;
        end else if (lowv) begin
          p = `CTST_PH_PRE;
        end else if (cv) begin
          p = `CTST_PH_CV;
        end else begin
          p = `CTST_PH_CC;
        end
      end
      S_TOPOFF: p = `CTST_PH_TOPOFF;
      S_DONE:   p = `CTST_PH_DONE;
      default:  p = `CTST_PH_IDLE;
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  ctst_core_t  r;
  ctst_core_t  next_r;
  logic        en;
  logic        en_rise;
  logic        out_win;
  logic        zone_susp;
  logic        regul;
  logic        hold;
  logic        half;
  logic        adv;
  logic        term_ok;
  logic        rechg;
  logic        restart;
  logic        st_clr;
  logic        st_run;
  logic [16:0] st_lim;
  logic        st_exp;
  logic        to_exp;
  logic        reg_rst;

  ctst_if tk ();

  ctst_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tk     (tk)
  );

  assign en        = r.ctrl[`CTST_CTRL_EN] & ~charge_disable_pin_i;
  assign en_rise   = en & ~r.en_d;
  assign out_win   = thermistor_cold_i | thermistor_hot_i; // R11
  assign zone_susp = out_win
                   | (thermistor_warm_i & (r.cfg[`CTST_CFG_WV] == 2'h3))  // R12
                   | (thermistor_cool_i & (r.cfg[`CTST_CFG_CI] == 2'h3)); // R14
  assign regul     = input_current_loop_status_i | input_voltage_loop_i | thermal_reg_i;
  assign hold      = charge_fault_i | supplement_i | zone_susp; // R19
  // half rate only slows a running count; the count itself is never touched
  assign half      = r.ctrl[`CTST_CTRL_HR] & (regul | balance_active_i); // R17 R18
  assign adv       = tk.tick & (~half | r.hp); // R23
  // precharge region is excluded: only fast-charge phases may terminate
  assign term_ok   = vbat_above_recharge_i & ibat_below_term_i // R1
                   & r.ctrl[`CTST_CTRL_TE]                   // R4
                   & ~regul                                  // R3
                   & ~thermistor_warm_i & ~thermistor_cool_i // R15
                   & ~hold & ~vbat_below_lowv_i;
  assign rechg     = ~vbat_above_recharge_i;
  assign restart   = ((r.st == S_TOPOFF) | (r.st == S_DONE)) & en & rechg;
  assign st_clr    = en_rise | restart | (vbat_below_lowv_i != r.lowv_d); // R20
  assign st_run    = ((r.st == S_CHG) | (r.st == S_TOPOFF)) & ~hold
                   & r.ctrl[`CTST_CTRL_TM]; // R16
  assign st_lim    = vbat_below_lowv_i ? 17'(`CTST_PRE_HR * `CTST_S_PER_HR) // R21
                                       : fast_lim(r.cfg[`CTST_CFG_FAST]);
  assign st_exp    = st_run & (r.st_cnt >= st_lim);
  assign to_exp    = (r.st == S_TOPOFF) & (r.to_cnt >= to_lim(r.to_sel)); // R7
  assign reg_rst   = wr_i & (addr_i == `CTST_CTRL_OFS) & wdata_i[`CTST_CTRL_RSTB];

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r          = r;
    next_r.alert    = 1'b0;
    next_r.rdata    = 16'h0000;
    next_r.stat_lvl = 1'b0;
    next_r.en_d     = en;
    next_r.lowv_d   = vbat_below_lowv_i;
    if (wr_i && (addr_i == `CTST_CTRL_OFS)) begin
      next_r.ctrl = wdata_i[4:0];
    end
    if (wr_i && (addr_i == `CTST_CFG_OFS)) begin
      next_r.cfg = wdata_i[8:0];
    end
    if (rd_i) begin
      case (addr_i)
        `CTST_CTRL_OFS: next_r.rdata = {11'h000, r.ctrl};
        `CTST_CFG_OFS:  next_r.rdata = {7'h00, r.cfg};
        `CTST_STAT_OFS: next_r.rdata = {9'h000, r.st == S_TOPOFF, half, ~out_win,
                                        r.tfault, r.phase};
        default:        next_r.rdata = 16'h0000;
      endcase
    end
    if (tk.tick && half) begin
      next_r.hp = ~r.hp; // R23
    end
    if (st_clr) begin
      next_r.st_cnt = 17'h00000; // R20
    end else if (st_run && adv && !st_exp) begin
      next_r.st_cnt = r.st_cnt + 17'h00001; // R17 R21
    end
    if ((r.st == S_TOPOFF) && !hold && adv && !to_exp) begin
      next_r.to_cnt = r.to_cnt + 12'h001; // R6
    end
    case (r.st)
      S_IDLE: begin
        if (en && !out_win && !r.tfault) begin
          next_r.st = S_CHG; // R11
        end
      end
      S_CHG: begin
        if (!en) begin
          next_r.st = S_IDLE;
        end else if (st_exp) begin
          next_r.st     = S_IDLE;
          next_r.tfault = 1'b1; // R16
        end else if (term_ok) begin
          next_r.to_sel = r.cfg[`CTST_CFG_TO]; // R9
          next_r.to_cnt = 12'h000;            // R8
          next_r.st     = (r.cfg[`CTST_CFG_TO] != 2'h0) ? S_TOPOFF : S_DONE; // R5 R2
        end
      end
      S_TOPOFF: begin
        if (!en) begin
          next_r.st = S_IDLE;
        end else if (st_exp) begin
          next_r.st     = S_IDLE;
          next_r.tfault = 1'b1;
        end else if (rechg) begin
          next_r.st = S_CHG;
        end else if (to_exp) begin
          next_r.st = S_DONE; // R7
        end
      end
      S_DONE: begin
        if (!en) begin
          next_r.st = S_IDLE;
        end else if (rechg) begin
          next_r.st = S_CHG;
        end
      end
      default: next_r.st = S_IDLE;
    endcase
    if (en_rise) begin
      next_r.tfault = 1'b0;
      next_r.to_cnt = 12'h000; // R8
    end
    if (reg_rst) begin
      // restoring defaults zeroes the top-off selection, disabling it
      next_r.ctrl   = `CTST_CTRL_RST;
      next_r.cfg    = `CTST_CFG_RST;
      next_r.to_sel = 2'h0;
      next_r.to_cnt = 12'h000; // R8
    end
    next_r.phase   = phase_of(next_r.st, hold, vbat_below_short_i, vbat_below_lowv_i,
                              cv_mode_i);
    next_r.alert   = ((next_r.phase != r.phase) & ~r.ctrl[`CTST_CTRL_MASK]) // R10 R2 R5
                   | (next_r.tfault & ~r.tfault);                           // R16
    next_r.stat_oe = (next_r.st == S_CHG) & ~hold; // R2
    next_r.chg_on  = ((next_r.st == S_CHG) | (next_r.st == S_TOPOFF)) & ~hold;
    next_r.vsel    = thermistor_warm_i ? r.cfg[`CTST_CFG_WV] : 2'h0; // R12
    if (thermistor_warm_i) begin
      next_r.isel = {1'b0, r.cfg[`CTST_CFG_WI]}; // R13
    end else if (thermistor_cool_i) begin
      next_r.isel = r.cfg[`CTST_CFG_CI]; // R14
    end else begin
      next_r.isel = 2'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r      <= '0;
      r.ctrl <= `CTST_CTRL_RST;
      r.cfg  <= `CTST_CFG_RST;
    end else begin
      r <= next_r;
    end
  end

  assign rdata_o             = r.rdata;
  assign stat_o              = r.stat_lvl;
  assign stat_oe_o           = r.stat_oe;
  assign alert_o             = r.alert;
  assign charge_phase_code_o = r.phase;
  assign chg_on_o            = r.chg_on;
  assign vreg_sel_o          = r.vsel;
  assign ichg_scale_o        = r.isel;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_enter_topoff;
    (r.st == S_CHG) ##1 (r.st == S_TOPOFF);
  endsequence

  sequence s_leave_topoff;
    (r.st == S_TOPOFF) ##1 (r.st == S_DONE);
  endsequence

  AST_TERM_QUAL: assert property ( // R1
    ($past(r.st) == S_CHG && (r.st == S_DONE || r.st == S_TOPOFF))
      |-> $past(vbat_above_recharge_i && ibat_below_term_i))
    else $error("termination without battery conditions");
  AST_STAT_REL: assert property ((r.phase == `CTST_PH_DONE) |-> !stat_oe_o) // R2
    else $error("status pin driven after termination");
  AST_NO_TERM_REG: assert property ( // R3
    (r.st == S_CHG && regul) |=> !(r.st == S_DONE || r.st == S_TOPOFF))
    else $error("terminated during regulation");
  AST_TERM_OFF: assert property ( // R4
    (r.st == S_CHG && !r.ctrl[`CTST_CTRL_TE]) |=> (r.st != S_DONE && r.st != S_TOPOFF))
    else $error("terminated with termination disabled");
  AST_TOPOFF_ENTRY: assert property ( // R5
    s_enter_topoff |-> (r.phase == `CTST_PH_TOPOFF && r.to_cnt == 12'h000))
    else $error("top-off entry wrong");
  AST_TO_PAUSE: assert property ( // R6
    (r.st == S_TOPOFF && hold && !reg_rst) |=> $stable(r.to_cnt))
    else $error("top-off counted while suspended");
  AST_TO_EXPIRE: assert property (s_leave_topoff |-> r.phase == `CTST_PH_DONE) // R7
    else $error("top-off expiry code wrong");
  AST_TO_LATCH: assert property ( // R9
    s_enter_topoff |-> (r.to_sel == $past(r.cfg[`CTST_CFG_TO])))
    else $error("top-off duration not latched");
  AST_ALERT_CAUSE: assert property ( // R10
    (alert_o && !$rose(r.tfault)) |-> (!$past(r.ctrl[`CTST_CTRL_MASK]) && $changed(r.phase)))
    else $error("alert without unmasked phase change");
  AST_WIN: assert property (($past(r.st) == S_IDLE && r.st == S_CHG) |-> $past(!out_win)) // R11
    else $error("cycle started outside window");
  AST_WARM_V: assert property ( // R12
    thermistor_warm_i |=> (vreg_sel_o == $past(r.cfg[`CTST_CFG_WV])))
    else $error("warm voltage selection not applied");
  AST_ZONE_TERM: assert property ( // R15
    (r.st == S_CHG && (thermistor_warm_i || thermistor_cool_i))
      |=> (r.st != S_DONE && r.st != S_TOPOFF))
    else $error("terminated in warm or cool zone");
  AST_FAULT: assert property ($rose(r.tfault) |-> (alert_o && r.phase == `CTST_PH_IDLE)) // R16
    else $error("timer fault without alert");
  AST_HOLD: assert property ((hold && !st_clr) |=> $stable(r.st_cnt)) // R19
    else $error("safety timer counted while held");
  AST_CLR: assert property (st_clr |=> (r.st_cnt == 17'h00000)) // R20
    else $error("safety timer not cleared");
endmodule
